// *** epw_assertions.sv ***
// port checker for the enhanced pwm block
`timescale 1ns/10ps
module epw_assertions (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic clk_monitor_en_i,
  input wire logic primary_fail_i,
  input wire logic [3:0] pwm_o,
  input wire logic [3:0] pwm_oe_o,
  input wire logic period_timer_flag_o,
  input wire logic oscillator_fail_flag_o,
  input wire logic internal_osc_run_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // multi-step causes
  sequence s_asleep;
    sleep_i [*4];
  endsequence
  sequence s_clk_lost;
    (clk_monitor_en_i && primary_fail_i) [*2];
  endsequence
  // bus handshake
  a_ack_resp: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // reset, power states and flag hold
  a_rst_quiet: assert property ($fell(sys_rst_i) |-> pwm_oe_o == 4'h0 && !internal_osc_run_o)
    else $error("outputs not quiet after reset");
  a_sleep_frz: assert property (s_asleep |=> $stable(pwm_o) && $stable(pwm_oe_o))
    else $error("pins moved during sleep");
  a_fail_swap: assert property (s_clk_lost |-> ##[0:2] (internal_osc_run_o && oscillator_fail_flag_o))
    else $error("clock failure not handled");
  a_intrun_hold: assert property (internal_osc_run_o |=> internal_osc_run_o)
    else $error("internal run dropped");
  a_tflag_hold: assert property (period_timer_flag_o
    && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h8) |=> period_timer_flag_o)
    else $error("timer flag lost without clear");
endmodule

// *** epw_defs.svh ***
// register offsets, field positions and reset values of the enhanced pwm block
// Functional notes
// - pwm_mode_control bits 1:0 pick output polarity per pin pair.
// - period timer flag sets as each new pwm period begins.
// - after reset every pwm pin is high impedance until software enables it.
// - duty is duty_high_byte plus two low bits from mode bits 5:4.
// - half-bridge inserts deadband of seven-bit delay count.
// - shutdown_control holds source, two pair states and event status.
// - bit 7 of restart register enables auto-restart when cause clears.
// - sleep freezes timer and state; driven pins keep their value.
// - primary idle keeps primary clock; other modes use their own clock.
// - primary clock failure with monitor: internal run, fail flag, internal clock.
// - any reset forces pins input and all registers to reset values.
// - mode bits 7:6 pick output configuration and direction.
// - small package: pair b/d states and deadband bits read zero.
// - after event status clears, output resumes at next period start.
// - writes to event status ignored while shutdown condition is active.
`ifndef EPW_DEFS_SVH
`define EPW_DEFS_SVH
`define EPW_ADR_MODE 4'h0
`define EPW_ADR_SHDN 4'h1
`define EPW_ADR_RSDB 4'h2
`define EPW_ADR_TCTL 4'h3
`define EPW_ADR_TCNT 4'h4
`define EPW_ADR_PLIM 4'h5
`define EPW_ADR_DUTH 4'h6
`define EPW_ADR_DUTS 4'h7
`define EPW_ADR_FLAG 4'h8
`define EPW_ADR_PDIR 4'h9
`define EPW_ADR_CLKS 4'hA
`define EPW_RST_BYTE 8'h00
`define EPW_RST_PDIR 4'hF
`define EPW_RST_PLIM 8'hFF
`define EPW_FLG_TMR 0
`define EPW_FLG_OSC 1
`define EPW_SHD_ASE 7
`define EPW_RSD_PRS 7
`define EPW_TCT_RUN 2
`define EPW_CLK_SLEEP 0
`define EPW_CLK_IDLE 1
`define EPW_CLK_ALT 2
`define EPW_CLK_MON 3
`endif

// *** epw_pkg.sv ***
// types of the enhanced pwm block
package epw_pkg;
  typedef enum logic [1:0] {
    EPW_CFG_SINGLE,
    EPW_CFG_FWD,
    EPW_CFG_HALF,
    EPW_CFG_REV
  } epw_cfg_t;
  typedef enum logic [1:0] {
    EPW_SRC_PRIMARY,
    EPW_SRC_ALT,
    EPW_SRC_INTERNAL,
    EPW_SRC_STOPPED
  } epw_clk_t;
endpackage

// *** epw_switch_model.sv ***
// power switch stage with pull-down on every pwm pin
`timescale 1ns/10ps
module epw_switch_model (
  input wire logic [3:0] pwm_i,
  input wire logic [3:0] oe_i,
  output logic [3:0] pad_o
);
  // released pins sink low so switches stay off
  assign pad_o = pwm_i & oe_i;
endmodule

// *** epw_sync.sv ***
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module epw_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // shift chain; first stage read only by second
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_o <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// *** epw_top.sv ***
// enhanced pwm generator with wishbone register slave
`timescale 1ns/10ps
`include "epw_defs.svh"
module epw_top #(
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] fault_i,
  input wire logic sleep_i,
  input wire logic primary_idle_i,
  input wire logic alt_clk_en_i,
  input wire logic int_clk_en_i,
  input wire logic clk_monitor_en_i,
  input wire logic primary_fail_i,
  output logic [3:0] pwm_o,
  output logic [3:0] pwm_oe_o,
  output logic period_timer_flag_o,
  output logic oscillator_fail_flag_o,
  output logic internal_osc_run_o
);
  logic [7:0] mode_q;
  logic [7:0] shdn_q;
  logic [7:0] rsdb_q;
  logic [7:0] tctl_q;
  logic [7:0] tcnt_q;
  logic [7:0] plim_q;
  logic [7:0] duth_q;
  logic [7:0] duts_q;
  logic [3:0] pdir_q;
  logic [1:0] dlow_q;
  logic [3:0] pre_q;
  logic [1:0] sub_q;
  logic [6:0] db_q;
  logic [6:0] db_now;
  logic act_q;
  logic act_d;
  logic tick;
  logic run_en;
  logic wr;
  logic [2:0] flt;
  logic [2:0] flt_mon;
  logic fault_now;
  logic [9:0] cnt10;
  logic [9:0] duty10;
  logic raw;
  logic raw_prev_q;
  logic [3:0] drv;
  logic [3:0] hiz;
  logic period_end;
  logic [1:0] mon_q;
  epw_pkg::epw_clk_t src;
  epw_pkg::epw_cfg_t cfg;

  epw_sync #(
    .W(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(fault_i),
    .level_o(flt)
  );

  // fault source decode by source select
  function automatic logic fault_sel(input logic [2:0] sel, input logic [2:0] f);
    case (sel)
      3'h1: fault_sel = f[1];
      3'h2: fault_sel = f[2];
      3'h3: fault_sel = f[1] | f[2];
      3'h4: fault_sel = f[0];
      3'h5: fault_sel = f[0] | f[1];
      3'h6: fault_sel = f[0] | f[2];
      3'h7: fault_sel = |f;
      default: fault_sel = 1'b0;
    endcase
  endfunction

  assign flt_mon = flt;
  assign fault_now = fault_sel(shdn_q[6:4], flt_mon);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign cfg = epw_pkg::epw_cfg_t'(mode_q[7:6]);

  // timer clock source per power mode
  always_comb begin
    if (sleep_i) begin
      src = epw_pkg::EPW_SRC_STOPPED;
    end else if (internal_osc_run_o) begin
      src = epw_pkg::EPW_SRC_INTERNAL;
    end else if (primary_idle_i) begin
      src = epw_pkg::EPW_SRC_PRIMARY;
    end else if (alt_clk_en_i) begin
      src = epw_pkg::EPW_SRC_ALT;
    end else begin
      src = epw_pkg::EPW_SRC_PRIMARY;
    end
  end

  // timer input enable from the selected source
  always_comb begin
    case (src)
      epw_pkg::EPW_SRC_PRIMARY: run_en = 1'b1;
      epw_pkg::EPW_SRC_ALT: run_en = alt_clk_en_i;
      epw_pkg::EPW_SRC_INTERNAL: run_en = int_clk_en_i;
      default: run_en = 1'b0;
    endcase
  end

  // prescale divider: 1, 4 or 16
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pre_q <= 4'h0;
    end else if (run_en && tctl_q[`EPW_TCT_RUN]) begin
      pre_q <= pre_q + 4'h1;
    end
  end
  always_comb begin
    case (tctl_q[1:0])
      2'h0: tick = run_en & tctl_q[`EPW_TCT_RUN];
      2'h1: tick = run_en & tctl_q[`EPW_TCT_RUN] & (pre_q[1:0] == 2'h3);
      default: tick = run_en & tctl_q[`EPW_TCT_RUN] & (pre_q == 4'hF);
    endcase
  end

  assign period_end = tick & (sub_q == 2'h3) & (tcnt_q == plim_q);
  assign cnt10 = {tcnt_q, sub_q};
  assign duty10 = {duts_q, dlow_q};

  // period timer with quarter-step sub count
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tcnt_q <= `EPW_RST_BYTE;
      sub_q <= 2'h0;
    end else if (wr && wb_adr_i == `EPW_ADR_TCNT) begin
      tcnt_q <= wb_dat_i[7:0];
      sub_q <= 2'h0;
    end else if (tick) begin
      sub_q <= sub_q + 2'h1;
      if (sub_q == 2'h3) begin
        tcnt_q <= (tcnt_q == plim_q) ? 8'h00 : tcnt_q + 8'h01;
      end
    end
  end

  // latch duty at period start into shadow
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      duts_q <= `EPW_RST_BYTE;
      dlow_q <= 2'h0;
    end else if (period_end) begin
      duts_q <= duth_q;
      dlow_q <= mode_q[5:4];
    end
  end

  assign raw = (cnt10 < duty10) && (mode_q[3:2] == 2'h3);

  // deadband left in this cycle; an edge of raw reloads the full delay at once
  assign db_now = (raw != raw_prev_q) ? (SMALL_PKG ? 7'h00 : rsdb_q[6:0]) : db_q;

  // deadband counter; the edge cycle is already the first delay cycle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      db_q <= 7'h00;
      raw_prev_q <= 1'b0;
    end else if (run_en) begin
      raw_prev_q <= raw;
      db_q <= (db_now != 7'h00) ? db_now - 7'h01 : 7'h00;
    end
  end

  // output steering per configuration
  always_comb begin
    drv = 4'h0;
    case (cfg)
      epw_pkg::EPW_CFG_SINGLE: drv = {raw, raw, raw, raw};
      epw_pkg::EPW_CFG_FWD: drv = {raw, 1'b0, 1'b0, 1'b1};
      epw_pkg::EPW_CFG_HALF: drv = {1'b0, 1'b0, ~raw & (db_now == 7'h00), raw & (db_now == 7'h00)};
      epw_pkg::EPW_CFG_REV: drv = {1'b0, 1'b1, raw, 1'b0};
      default: drv = 4'h0;
    endcase
  end

  // shutdown event status with set-over-clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      act_q <= 1'b0;
    end else if (fault_now) begin
      act_q <= 1'b1;
    end else if (wr && wb_adr_i == `EPW_ADR_SHDN) begin
      act_q <= act_q; // resume waits for period start
    end else if (period_end) begin
      act_q <= shdn_q[`EPW_SHD_ASE];
    end
  end

  // pin levels and enables, held in sleep
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pwm_o <= 4'h0;
      pwm_oe_o <= 4'h0;
    end else if (!sleep_i) begin
      for (int i = 0; i < 4; i++) begin
        if (act_q) begin
          case (i[0] ? shdn_q[1:0] : shdn_q[3:2])
            2'h0: pwm_o[i] <= 1'b0;
            2'h1: pwm_o[i] <= 1'b1;
            default: pwm_o[i] <= 1'b0;
          endcase
        end else begin
          pwm_o[i] <= drv[i] ^ (i[0] ? mode_q[0] : mode_q[1]);
        end
      end
      pwm_oe_o <= ~pdir_q & ~hiz;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hiz[i] = act_q & (i[0] ? shdn_q[1] : shdn_q[3]);
    end
  end

  // registers and status flags
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mode_q <= `EPW_RST_BYTE;
      shdn_q <= `EPW_RST_BYTE;
      rsdb_q <= `EPW_RST_BYTE;
      tctl_q <= `EPW_RST_BYTE;
      plim_q <= `EPW_RST_PLIM;
      duth_q <= `EPW_RST_BYTE;
      pdir_q <= `EPW_RST_PDIR;
      period_timer_flag_o <= 1'b0;
      oscillator_fail_flag_o <= 1'b0;
      internal_osc_run_o <= 1'b0;
      mon_q <= 2'h0;
    end else begin
      mon_q <= {mon_q[0], clk_monitor_en_i & primary_fail_i};
      if (mon_q[1]) begin
        internal_osc_run_o <= 1'b1;
      end
      if (wr) begin
        case (wb_adr_i)
          `EPW_ADR_MODE: mode_q <= wb_dat_i[7:0];
          `EPW_ADR_SHDN: shdn_q <= {shdn_q[7], wb_dat_i[6:2], SMALL_PKG ? 2'h0 : wb_dat_i[1:0]};
          `EPW_ADR_RSDB: rsdb_q <= {wb_dat_i[7], SMALL_PKG ? 7'h00 : wb_dat_i[6:0]};
          `EPW_ADR_TCTL: tctl_q <= wb_dat_i[7:0];
          `EPW_ADR_PLIM: plim_q <= wb_dat_i[7:0];
          `EPW_ADR_DUTH: duth_q <= wb_dat_i[7:0];
          `EPW_ADR_PDIR: pdir_q <= wb_dat_i[3:0];
          default: ;
        endcase
      end
      // event status: fault sets, restart clears, guarded write
      if (fault_now) begin
        shdn_q[`EPW_SHD_ASE] <= 1'b1;
      end else if (rsdb_q[`EPW_RSD_PRS] && shdn_q[`EPW_SHD_ASE] && !act_q) begin
        shdn_q[`EPW_SHD_ASE] <= 1'b0;
      end else if (rsdb_q[`EPW_RSD_PRS] && act_q && shdn_q[6:4] != 3'h0) begin
        shdn_q[`EPW_SHD_ASE] <= 1'b0;
      end else if (wr && wb_adr_i == `EPW_ADR_SHDN) begin
        shdn_q[`EPW_SHD_ASE] <= wb_dat_i[7];
      end
      // flags: hardware set wins over software clear
      if (period_end) begin
        period_timer_flag_o <= 1'b1;
      end else if (wr && wb_adr_i == `EPW_ADR_FLAG && wb_dat_i[`EPW_FLG_TMR]) begin
        period_timer_flag_o <= 1'b0;
      end
      if (mon_q[1] && !internal_osc_run_o) begin
        oscillator_fail_flag_o <= 1'b1;
      end else if (wr && wb_adr_i == `EPW_ADR_FLAG && wb_dat_i[`EPW_FLG_OSC]) begin
        oscillator_fail_flag_o <= 1'b0;
      end
    end
  end

  // wishbone ack and read data
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        `EPW_ADR_MODE: wb_dat_o[7:0] <= mode_q;
        `EPW_ADR_SHDN: wb_dat_o[7:0] <= shdn_q;
        `EPW_ADR_RSDB: wb_dat_o[7:0] <= rsdb_q;
        `EPW_ADR_TCTL: wb_dat_o[7:0] <= tctl_q;
        `EPW_ADR_TCNT: wb_dat_o[7:0] <= tcnt_q;
        `EPW_ADR_PLIM: wb_dat_o[7:0] <= plim_q;
        `EPW_ADR_DUTH: wb_dat_o[7:0] <= duth_q;
        `EPW_ADR_DUTS: wb_dat_o[7:0] <= duts_q;
        `EPW_ADR_FLAG: wb_dat_o[1:0] <= {oscillator_fail_flag_o, period_timer_flag_o};
        `EPW_ADR_PDIR: wb_dat_o[3:0] <= pdir_q;
        `EPW_ADR_CLKS: wb_dat_o[3:0] <= {clk_monitor_en_i, internal_osc_run_o, primary_idle_i, sleep_i};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// *** tb.sv ***
// self-checking bench for the enhanced pwm block
`timescale 1ns/10ps
module tb;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic slp = 1'b0;
  logic idl = 1'b0;
  logic mon = 1'b0;
  logic pfail = 1'b0;
  logic ick = 1'b1;
  logic [2:0] flt = 3'h0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, tflag, oflag, irun;
  logic [3:0] pwm, oe, pad;
  logic [7:0] r;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  // clock
  always #5 mclk_i = ~mclk_i;
  epw_top #(.SMALL_PKG(1'b0)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .fault_i(flt), .sleep_i(slp), .primary_idle_i(idl),
    .alt_clk_en_i(1'b1), .int_clk_en_i(ick), .clk_monitor_en_i(mon),
    .primary_fail_i(pfail), .pwm_o(pwm), .pwm_oe_o(oe), .period_timer_flag_o(tflag),
    .oscillator_fail_flag_o(oflag), .internal_osc_run_o(irun));
  epw_switch_model u_sw (.pwm_i(pwm), .oe_i(oe), .pad_o(pad));
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge mclk_i); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(r, e);
  endtask
  // driven high cycles of out_a (and out_b if eb given) over one 16-cycle period
  task automatic hi(input int e, input int eb = -1);
    int n;
    int nb;
    n = 0;
    nb = 0;
    repeat (32) @(posedge mclk_i);
    repeat (16) begin
      @(posedge mclk_i);
      n += (pad[0] === 1'b1);
      nb += (pad[1] === 1'b1);
    end
    chk(n, e);
    if (eb >= 0) chk(nb, eb);
  endtask
  task automatic t_reset;
    chk(oe, 4'h0);
    for (int i = 0; i < 12; i++) rd(i[3:0], i == 5 ? 8'hFF : i == 9 ? 8'h0F : 8'h00);
  endtask
  task automatic t_setup;
    wr(4'h9, 8'h0F);
    wr(4'h5, 8'h03);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h1C);
    wr(4'h6, 8'h01);
    wr(4'h8, 8'h01);
    wr(4'h3, 8'h04);
    chk(tflag, 1'b0);
    for (int i = 0; i < 200 && tflag !== 1'b1; i++) @(posedge mclk_i);
    chk(tflag, 1'b1);
    chk(pad, 4'h0);
    wr(4'h9, 8'h00);
    wr(4'h1, 8'h00);
    chk(oe[0], 1'b1);
    hi(5);
    for (int p = 0; p < 2; p++) begin
      wr(4'h9, 8'h0F);
      wr(4'h0, p == 0 ? 8'h1F : 8'h1C);
      wr(4'h9, 8'h00);
      hi(p == 0 ? 11 : 5);
    end
  endtask
  task automatic t_shut;
    wr(4'h2, 8'h00);
    wr(4'h1, 8'h48);
    flt <= 3'h1;
    repeat (8) @(posedge mclk_i);
    rd(4'h1, 8'hC8);
    chk(oe[0], 1'b0);
    wr(4'h1, 8'h48);
    rd(4'h1, 8'hC8);
    flt <= 3'h0;
    repeat (8) @(posedge mclk_i);
    rd(4'h1, 8'hC8);
    wr(4'h1, 8'h48);
    hi(5);
    wr(4'h2, 8'hFF);
    rd(4'h2, 8'hFF);
    flt <= 3'h1;
    repeat (8) @(posedge mclk_i);
    rd(4'h1, 8'hC8);
    flt <= 3'h0;
    repeat (8) @(posedge mclk_i);
    rd(4'h1, 8'h48);
    wr(4'h2, 8'h02);
    // forward, half-bridge with two-cycle deadband, reverse, back to single
    for (int c = 1; c < 5; c++) begin
      wr(4'h9, 8'h0F);
      wr(4'h0, {c[1:0], 6'h1C});
      wr(4'h9, 8'h00);
      hi(c == 1 ? 16 : c == 2 ? 3 : c == 3 ? 0 : 5, c == 1 ? 0 : c == 2 ? 9 : 5);
    end
  endtask
  task automatic t_power;
    logic [3:0] p;
    logic [7:0] t0;
    slp <= 1'b1;
    repeat (4) @(posedge mclk_i);
    p = pad;
    rd(4'hA, 8'h01);
    repeat (20) @(posedge mclk_i);
    chk(pad, p);
    slp <= 1'b0;
    idl <= 1'b1;
    rd(4'hA, 8'h02);
    hi(5);
    idl <= 1'b0;
    mon <= 1'b1;
    pfail <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk({oflag, irun}, 2'h3);
    rd(4'hA, 8'h0C);
    hi(5);
    ick <= 1'b0;
    wb(1'b0, 4'h4, 8'h00);
    t0 = r;
    repeat (8) @(posedge mclk_i);
    wb(1'b0, 4'h4, 8'h00);
    chk(r, t0);
    ick <= 1'b1;
    mon <= 1'b0;
    pfail <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    chk(irun, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_setup();
    t_shut();
    t_power();
    t_reset();
    close_out;
  end
endmodule
bind epw_top epw_assertions u_chk (.mclk_i, .sys_rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .sleep_i, .clk_monitor_en_i, .primary_fail_i, .pwm_o, .pwm_oe_o,
  .period_timer_flag_o, .oscillator_fail_flag_o, .internal_osc_run_o);
